// ---- rtl/cpdma_buf2.sv ----
// two-entry word buffer between the read and write halves of a transfer
`timescale 1ns/10ps
module cpdma_buf2 #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);

   typedef struct packed {
      logic [1:0][W-1:0] mem;
      logic wr_ptr;
      logic rd_ptr;
      logic [1:0] count;
   } cpdma_buf_t;

   cpdma_buf_t r;
   cpdma_buf_t nxt;
   logic push;
   logic pop;

   // handshakes come straight from the occupancy count
   assign in_ready = (r.count != 2'd2);
   assign out_valid = (r.count != 2'd0);
   assign out_data = r.mem[r.rd_ptr];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // pointer and count update, flush empties the buffer
   always_comb begin
      nxt = r;
      if (push) begin
         nxt.mem[r.wr_ptr] = in_data;
         nxt.wr_ptr = ~r.wr_ptr;
      end
      if (pop) begin
         nxt.rd_ptr = ~r.rd_ptr;
      end
      if (push && !pop) begin
         nxt.count = r.count + 2'd1;
      end else if (pop && !push) begin
         nxt.count = r.count - 2'd1;
      end
      if (flush) begin
         nxt.wr_ptr = 1'b0;
         nxt.rd_ptr = 1'b0;
         nxt.count = 2'd0;
      end
   end

   // state register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r <= '0;
      end else begin
         r <= nxt;
      end
   end

endmodule // cpdma_buf2

// ---- rtl/cpdma_channel.sv ----
// one paced dma channel copying 16-bit words between regions a and b
//
// Notes on behaviour
// [RQ1] select bit 0 paces from codec sample trigger; value 1 is reserved
// [RQ2] with abort bit set, clearing active stops the channel at once
// [RQ3] one-shot mode stops when a offset equals transfer length
// [RQ4] wrap mode clears both offsets at length and keeps going
// [RQ5] step code 00 holds offset, 10 adds one word, 01 reserved
// [RQ6] paced start 0 runs at once; 1 waits a codec trigger per word
// [RQ7] software always writes 1 to the must-set bit
// [RQ8] direction 0 copies a to b, direction 1 copies b to a
// [RQ9] active 0 keeps channel idle and clocks gated; 1 enables it
// [RQ10] one-shot completion clears the active bit by hardware
// [RQ11] software sets abort bit before clearing active to stop early
// [RQ12] side address is base plus offset; offset steps 0 or 2
// [RQ13] software keeps length at most 0xFF minus a-side step
// [RQ14] each word is read from source, written to destination, then step
// [RQ15] all control fields reset to zero: off, one-shot, a to b
`timescale 1ns/10ps
module cpdma_channel
   import cpdma_pkg::*;
#(
   parameter int AW = 16,
   parameter int MAW = 13
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [AW-1:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic codec_trig,
   output logic mem_req,
   output logic mem_we,
   output logic [MAW-1:0] mem_addr,
   output logic [15:0] mem_wdata,
   input wire logic mem_gnt,
   input wire logic mem_rvalid,
   input wire logic [15:0] mem_rdata,
   output logic chan_clk_en
);

   cpd_core_t r;
   cpd_core_t nxt;
   logic trig_edge;
   logic abort_now;
   logic buf_in_valid;
   logic buf_in_ready;
   logic buf_out_valid;
   logic buf_out_ready;
   logic [15:0] buf_out_data;
   logic [12:0] src_addr;
   logic [12:0] dst_addr;
   logic [15:0] stat_word;

   // offset increment for one step code; reserved codes hold still
   function automatic logic [7:0] step_of(input logic [1:0] code);
      logic [7:0] inc;
      inc = 8'h00;
      if (code == CPD_STEP_WORD) begin
         inc = CPD_WORD_BYTES; // see [RQ5]
      end
      return inc;
   endfunction

   // word address of one side: base plus byte offset
   function automatic logic [12:0] side_addr(input logic [12:0] base,
                                             input logic [7:0] idx);
      return base + {5'h00, idx}; // see [RQ12]
   endfunction

   // register write with bits outside the writable mask forced to zero
   function automatic logic [15:0] ctrl_masked(input logic [15:0] v);
      return v & CPD_CTRL_WMASK;
   endfunction

   // source and destination chosen by the direction bit
   always_comb begin
      if (r.ctrl[CPD_DIR_BIT]) begin
         src_addr = side_addr(r.b_base, r.b_idx); // see [RQ8]
         dst_addr = side_addr(r.a_base, r.a_idx);
      end else begin
         src_addr = side_addr(r.a_base, r.a_idx); // see [RQ8]
         dst_addr = side_addr(r.b_base, r.b_idx);
      end
   end

   // rising edge of the synchronised codec sample trigger
   assign trig_edge = r.trig_sync & ~r.trig_prev;

   // read-only status word: busy, trigger pending and sequencer state
   always_comb begin
      stat_word = 16'h0000;
      stat_word[CPD_STAT_BUSY_BIT] = (r.st != CPD_ST_IDLE);
      stat_word[CPD_STAT_PEND_BIT] = r.trig_pend;
      stat_word[CPD_STAT_STATE_LSB +: 3] = r.st;
   end

   // buffer handshakes: push on read return, pop when loading a write
   assign buf_in_valid = (r.st == CPD_ST_RWAIT) & mem_rvalid;
   assign buf_out_ready = (r.st == CPD_ST_WRITE) & ~r.mem_req;

   // next-state logic of the whole channel
   always_comb begin
      nxt = r;
      nxt.rdata = 16'h0000;
      abort_now = 1'b0;

      // codec trigger passes two flops before use
      nxt.trig_meta = codec_trig;
      nxt.trig_sync = r.trig_meta;
      nxt.trig_prev = r.trig_sync;

      // trigger is the only pacing source whatever select reads
      if (!r.ctrl[CPD_ACTIVE_BIT]) begin
         nxt.trig_pend = 1'b0;
      end else if (trig_edge) begin
         nxt.trig_pend = 1'b1; // see [RQ1]
      end

      // channel sequencer
      unique case (r.st)
         CPD_ST_IDLE: begin
            if (r.ctrl[CPD_ACTIVE_BIT]) begin
               nxt.st = CPD_ST_CHECK; // see [RQ9]
            end
         end
         CPD_ST_CHECK: begin
            if (!r.ctrl[CPD_ACTIVE_BIT]) begin
               nxt.st = CPD_ST_IDLE; // see [RQ9]
            end else if (r.a_idx == r.len) begin
               if (r.ctrl[CPD_WRAP_BIT]) begin
                  nxt.a_idx = CPD_IDX_RST; // see [RQ4]
                  nxt.b_idx = CPD_IDX_RST; // see [RQ4]
                  nxt.st = r.ctrl[CPD_PACED_BIT] ? CPD_ST_WAIT_TRIG
                                                 : CPD_ST_READ;
               end else begin
                  nxt.ctrl[CPD_ACTIVE_BIT] = 1'b0; // see [RQ3] [RQ10]
                  nxt.st = CPD_ST_IDLE;
               end
            end else if (r.ctrl[CPD_PACED_BIT]) begin
               nxt.st = CPD_ST_WAIT_TRIG; // see [RQ6]
            end else begin
               nxt.st = CPD_ST_READ; // see [RQ6]
            end
         end
         CPD_ST_WAIT_TRIG: begin
            if (!r.ctrl[CPD_ACTIVE_BIT]) begin
               nxt.st = CPD_ST_IDLE;
            end else if (r.trig_pend) begin
               nxt.trig_pend = trig_edge; // see [RQ6]
               nxt.st = CPD_ST_READ;
            end
         end
         CPD_ST_READ: begin
            // issue the source read only when the buffer has room
            if (!r.mem_req && buf_in_ready) begin
               nxt.mem_req = 1'b1; // see [RQ14]
               nxt.mem_we = 1'b0;
               nxt.mem_addr = src_addr;
            end else if (r.mem_req && mem_gnt) begin
               nxt.mem_req = 1'b0;
               nxt.st = CPD_ST_RWAIT;
            end
         end
         CPD_ST_RWAIT: begin
            if (mem_rvalid) begin
               nxt.st = CPD_ST_WRITE; // see [RQ14]
            end
         end
         CPD_ST_WRITE: begin
            // load the buffered word, then hold the write until granted
            if (!r.mem_req && buf_out_valid) begin
               nxt.mem_req = 1'b1; // see [RQ14]
               nxt.mem_we = 1'b1;
               nxt.mem_addr = dst_addr;
               nxt.mem_wdata = buf_out_data;
            end else if (r.mem_req && mem_gnt) begin
               nxt.mem_req = 1'b0;
               nxt.mem_we = 1'b0;
               nxt.st = CPD_ST_UPDATE;
            end
         end
         CPD_ST_UPDATE: begin
            // offsets move only after the word is written
            nxt.a_idx = r.a_idx + step_of(r.ctrl[CPD_A_STEP_LSB +: 2]);
            nxt.b_idx = r.b_idx + step_of(r.ctrl[CPD_B_STEP_LSB +: 2]);
            nxt.st = CPD_ST_CHECK; // see [RQ12] [RQ14]
         end
         default: begin
            nxt.st = CPD_ST_IDLE;
            nxt.mem_req = 1'b0;
            nxt.mem_we = 1'b0;
         end
      endcase

      // software writes override hardware updates of the same field
      if (reg_wr) begin
         unique case (reg_addr)
            CPD_A_BASE_OFS: nxt.a_base = reg_wdata[12:0];
            CPD_A_IDX_OFS: nxt.a_idx = reg_wdata[7:0];
            CPD_B_BASE_OFS: nxt.b_base = reg_wdata[12:0];
            CPD_B_IDX_OFS: nxt.b_idx = reg_wdata[7:0];
            CPD_LEN_OFS: nxt.len = reg_wdata[7:0];
            CPD_CTRL_OFS: nxt.ctrl = ctrl_masked(reg_wdata); // see [RQ7]
            default: ;
         endcase
      end

      // clearing active with abort set drops the word in flight
      if (r.st != CPD_ST_IDLE && !nxt.ctrl[CPD_ACTIVE_BIT]
          && nxt.ctrl[CPD_ABORT_BIT]) begin
         abort_now = 1'b1; // see [RQ2] [RQ11]
         nxt.st = CPD_ST_IDLE;
         nxt.mem_req = 1'b0;
         nxt.mem_we = 1'b0;
      end

      // read data stand in the cycle after the read strobe
      if (reg_rd) begin
         unique case (reg_addr)
            CPD_A_BASE_OFS: nxt.rdata = {3'b000, r.a_base};
            CPD_A_IDX_OFS: nxt.rdata = {8'h00, r.a_idx};
            CPD_B_BASE_OFS: nxt.rdata = {3'b000, r.b_base};
            CPD_B_IDX_OFS: nxt.rdata = {8'h00, r.b_idx};
            CPD_LEN_OFS: nxt.rdata = {8'h00, r.len};
            CPD_CTRL_OFS: nxt.rdata = r.ctrl;
            CPD_STAT_OFS: nxt.rdata = stat_word;
            default: nxt.rdata = 16'h0000;
         endcase
      end
   end

   // state register with documented reset values
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r.st <= CPD_ST_IDLE;
         r.ctrl <= CPD_CTRL_RST; // see [RQ15]
         r.a_base <= CPD_BASE_RST;
         r.b_base <= CPD_BASE_RST;
         r.a_idx <= CPD_IDX_RST;
         r.b_idx <= CPD_IDX_RST;
         r.len <= CPD_LEN_RST;
         r.trig_meta <= 1'b0;
         r.trig_sync <= 1'b0;
         r.trig_prev <= 1'b0;
         r.trig_pend <= 1'b0;
         r.mem_req <= 1'b0;
         r.mem_we <= 1'b0;
         r.mem_addr <= 13'h0000;
         r.mem_wdata <= 16'h0000;
         r.rdata <= 16'h0000;
      end else begin
         r <= nxt;
      end
   end

   // word buffer between read return and destination write
   cpdma_buf2 #(
      .W(16)
   ) u_buf (
      .clk(clk),
      .arst_n(arst_n),
      .flush(abort_now),
      .in_valid(buf_in_valid),
      .in_ready(buf_in_ready),
      .in_data(mem_rdata),
      .out_valid(buf_out_valid),
      .out_ready(buf_out_ready),
      .out_data(buf_out_data)
   );

   // outputs; clock enable drops once the channel is off and idle
   assign reg_rdata = r.rdata;
   assign mem_req = r.mem_req;
   assign mem_we = r.mem_we;
   assign mem_addr = r.mem_addr[MAW-1:0];
   assign mem_wdata = r.mem_wdata;
   assign chan_clk_en = r.ctrl[CPD_ACTIVE_BIT]
                      | (r.st != CPD_ST_IDLE); // see [RQ9]

endmodule // cpdma_channel

// ---- rtl/cpdma_pkg.sv ----
// constants and types shared by the paced dma channel files
package cpdma_pkg;

   // register offsets on the plain register port
   localparam logic [15:0] CPD_A_BASE_OFS = 16'h1250;
   localparam logic [15:0] CPD_A_IDX_OFS = 16'h1254;
   localparam logic [15:0] CPD_B_BASE_OFS = 16'h1256;
   localparam logic [15:0] CPD_B_IDX_OFS = 16'h125A;
   localparam logic [15:0] CPD_LEN_OFS = 16'h125E;
   localparam logic [15:0] CPD_CTRL_OFS = 16'h1260;
   localparam logic [15:0] CPD_STAT_OFS = 16'h1262;

   // channel_setup field positions
   localparam int CPD_SYNC_SEL_BIT = 14;
   localparam int CPD_ABORT_BIT = 11;
   localparam int CPD_WRAP_BIT = 10;
   localparam int CPD_A_STEP_LSB = 8;
   localparam int CPD_B_STEP_LSB = 6;
   localparam int CPD_PACED_BIT = 5;
   localparam int CPD_MUST_SET_BIT = 3;
   localparam int CPD_DIR_BIT = 2;
   localparam int CPD_ACTIVE_BIT = 0;

   // writable bits of channel_setup, the rest read as zero
   localparam logic [15:0] CPD_CTRL_WMASK = 16'h4FED;

   // status register field positions
   localparam int CPD_STAT_BUSY_BIT = 0;
   localparam int CPD_STAT_PEND_BIT = 1;
   localparam int CPD_STAT_STATE_LSB = 4;

   // reset values
   localparam logic [15:0] CPD_CTRL_RST = 16'h0000;
   localparam logic [12:0] CPD_BASE_RST = 13'h0000;
   localparam logic [7:0] CPD_IDX_RST = 8'h00;
   localparam logic [7:0] CPD_LEN_RST = 8'h00;

   // step codes and the size of one word in bytes
   localparam logic [1:0] CPD_STEP_HOLD = 2'b00;
   localparam logic [1:0] CPD_STEP_WORD = 2'b10;
   localparam logic [7:0] CPD_WORD_BYTES = 8'h02;

   // channel sequencer states
   typedef enum logic [2:0] {
      CPD_ST_IDLE = 3'b000,
      CPD_ST_CHECK = 3'b001,
      CPD_ST_WAIT_TRIG = 3'b010,
      CPD_ST_READ = 3'b011,
      CPD_ST_RWAIT = 3'b100,
      CPD_ST_WRITE = 3'b101,
      CPD_ST_UPDATE = 3'b110
   } cpd_state_t;

   // whole state of the channel core
   typedef struct packed {
      cpd_state_t st;
      logic [15:0] ctrl;
      logic [12:0] a_base;
      logic [12:0] b_base;
      logic [7:0] a_idx;
      logic [7:0] b_idx;
      logic [7:0] len;
      logic trig_meta;
      logic trig_sync;
      logic trig_prev;
      logic trig_pend;
      logic mem_req;
      logic mem_we;
      logic [12:0] mem_addr;
      logic [15:0] mem_wdata;
      logic [15:0] rdata;
   } cpd_core_t;

endpackage

// ---- testbench/cpdma_channel_bench.sv ----
// self-checking bench for the paced dma channel
`timescale 1ns/10ps
module cpdma_channel_bench import cpdma_pkg::*;;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic codec_trig = 1'b0;
   logic slow = 1'b0;
   logic [15:0] reg_rdata, mem_wdata, mem_rdata, v;
   logic [12:0] mem_addr;
   logic mem_req, mem_we, mem_gnt, mem_rvalid, chan_clk_en;
   int miscompares = 0;
   int comparisons = 0;

   // 100 MHz clock
   always #5 clk = ~clk;

   cpdma_channel dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .codec_trig(codec_trig), .mem_req(mem_req),
      .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
      .chan_clk_en(chan_clk_en));

   cpdma_mem_model mem_u (.clk(clk), .arst_n(arst_n), .slow(slow),
      .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid),
      .mem_rdata(mem_rdata));

   task automatic close_out;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string n, input logic [15:0] e,
         input logic [15:0] s);
      comparisons++;
      if (s !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask

   // register write, one strobe cycle then one idle cycle
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask

   // register read, data taken in the cycle after the strobe
   task automatic rdv(input logic [15:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
      @(posedge clk);
   endtask

   task automatic rd(input logic [15:0] a, input logic [15:0] e,
         input string n);
      rdv(a);
      chk(n, e, v);
   endtask

   // bases, zeroed offsets, length, then the control word last
   task automatic prog(input logic [15:0] ab, input logic [15:0] bb,
         input logic [15:0] ctl);
      wr(CPD_A_BASE_OFS, ab);
      wr(CPD_B_BASE_OFS, bb);
      wr(CPD_A_IDX_OFS, 16'h0000);
      wr(CPD_B_IDX_OFS, 16'h0000);
      wr(CPD_LEN_OFS, 16'h0004);
      wr(CPD_CTRL_OFS, ctl);
   endtask

   task automatic wait_off;
      int i;
      for (i = 0; i < 200; i++) begin
         rdv(CPD_CTRL_OFS);
         if (v[CPD_ACTIVE_BIT] === 1'b0)
            break;
      end
      if (i == 200) begin
         miscompares++;
         $display("BAD channel off expected 0 seen 1");
         close_out();
      end
   endtask

   task automatic pulse;
      codec_trig <= 1'b1;
      repeat (3) @(posedge clk);
      codec_trig <= 1'b0;
      repeat (30) @(posedge clk);
   endtask

   task automatic t_regs;
      logic [15:0] ofs [7] = '{CPD_A_BASE_OFS, CPD_A_IDX_OFS,
         CPD_B_BASE_OFS, CPD_B_IDX_OFS, CPD_LEN_OFS, CPD_CTRL_OFS,
         CPD_STAT_OFS};
      foreach (ofs[i])
         rd(ofs[i], 16'h0000, "reset value");
      rd(16'h1258, 16'h0000, "unmapped");
      wr(CPD_CTRL_OFS, 16'hFFFE);
      rd(CPD_CTRL_OFS, 16'h4FEC, "ctrl bits");
      wr(CPD_CTRL_OFS, 16'h0008);
      $display("test regs done");
   endtask

   task automatic t_oneshot;
      slow <= 1'b1;
      mem_u.m[7'h10] = 16'hA5C3;
      mem_u.m[7'h12] = 16'h3C5A;
      prog(16'h0010, 16'h0020, 16'h0289);
      wait_off();
      chk("dst word 0", 16'hA5C3, mem_u.m[7'h20]);
      chk("dst word 1", 16'h3C5A, mem_u.m[7'h22]);
      chk("clock enable", 16'h0000, {15'h0000, chan_clk_en});
      rd(CPD_A_IDX_OFS, 16'h0004, "a offset");
      rd(CPD_B_IDX_OFS, 16'h0004, "b offset");
      rd(CPD_CTRL_OFS, 16'h0288, "ctrl after end");
      slow <= 1'b0;
      $display("test one-shot done");
   endtask

   task automatic t_dir;
      mem_u.m[7'h30] = 16'h1234;
      prog(16'h0040, 16'h0030, 16'h020D);
      wait_off();
      chk("a word 0", 16'h1234, mem_u.m[7'h40]);
      chk("a word 1", 16'h1234, mem_u.m[7'h42]);
      rd(CPD_B_IDX_OFS, 16'h0000, "b held");
      $display("test direction done");
   endtask

   task automatic t_wrap;
      prog(16'h0010, 16'h0050, 16'h06A9);
      repeat (30) @(posedge clk);
      rd(CPD_A_IDX_OFS, 16'h0000, "no trigger");
      repeat (3) pulse();
      rd(CPD_A_IDX_OFS, 16'h0002, "a wrapped");
      rd(CPD_B_IDX_OFS, 16'h0002, "b wrapped");
      chk("wrap word", 16'h3C5A, mem_u.m[7'h52]);
      wr(CPD_CTRL_OFS, 16'h0EA8);
      pulse();
      rd(CPD_A_IDX_OFS, 16'h0002, "after abort");
      rd(CPD_CTRL_OFS, 16'h0EA8, "ctrl aborted");
      $display("test wrap done");
   endtask

   // reset, then the scenarios in turn
   initial begin
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      t_regs();
      t_oneshot();
      t_dir();
      t_wrap();
      close_out();
   end
endmodule // cpdma_channel_bench

// ---- testbench/cpdma_channel_sva.sv ----
// port checker for the paced dma channel
`timescale 1ns/10ps
module cpdma_channel_chk
   import cpdma_pkg::*;
#(
   parameter int AW = 16,
   parameter int MAW = 13
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [AW-1:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic codec_trig,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [MAW-1:0] mem_addr,
   input wire logic [15:0] mem_wdata,
   input wire logic mem_gnt,
   input wire logic mem_rvalid,
   input wire logic [15:0] mem_rdata,
   input wire logic chan_clk_en
);
   logic ctrl_wr, abort_wr, go_wr;
   logic paced_r, trig_prev_r, trig_ok_r;
   logic [7:0] len_r;
   logic [15:0] last_rd_r;

   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);

   // decode of software writes to the control register
   assign ctrl_wr = reg_wr && (reg_addr == CPD_CTRL_OFS);
   assign abort_wr = ctrl_wr && reg_wdata[CPD_ABORT_BIT]
      && !reg_wdata[CPD_ACTIVE_BIT];
   assign go_wr = ctrl_wr && reg_wdata[CPD_ACTIVE_BIT]
      && !reg_wdata[CPD_PACED_BIT];

   // shadows of pacing, length, trigger edges and the last word read
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         paced_r <= 1'b0;
         trig_prev_r <= 1'b0;
         trig_ok_r <= 1'b0;
         len_r <= 8'h00;
         last_rd_r <= 16'h0000;
      end else begin
         trig_prev_r <= codec_trig;
         if (ctrl_wr)
            paced_r <= reg_wdata[CPD_PACED_BIT];
         if (reg_wr && reg_addr == CPD_LEN_OFS)
            len_r <= reg_wdata[7:0];
         if (mem_rvalid)
            last_rd_r <= mem_rdata;
         if (codec_trig && !trig_prev_r)
            trig_ok_r <= 1'b1;
         else if (mem_req && mem_gnt && !mem_we)
            trig_ok_r <= 1'b0;
      end
   end

   property p_rd_idle;
      !$past(reg_rd) |-> reg_rdata == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data not zero outside a read");

   property p_rst_quiet;
      $rose(arst_n) |-> !mem_req && !chan_clk_en;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet)
      else $error("channel busy right after reset");

   property p_off_idle;
      !chan_clk_en |-> !mem_req;
   endproperty
   a_off_idle: assert property (p_off_idle)
      else $error("memory request while channel off");

   property p_abort;
      abort_wr |=> !mem_req [*4];
   endproperty
   a_abort: assert property (p_abort)
      else $error("request after abort");

   property p_hold;
      mem_req && !mem_gnt && !reg_wr |=>
         mem_req && $stable(mem_addr) && $stable(mem_we);
   endproperty
   a_hold: assert property (p_hold)
      else $error("request changed before grant");

   property p_wr_data;
      mem_req && mem_we |-> mem_wdata == last_rd_r;
   endproperty
   a_wr_data: assert property (p_wr_data)
      else $error("written word differs from word read");

   property p_start;
      go_wr && !chan_clk_en && len_r != 8'h00 |-> ##[1:5] mem_req;
   endproperty
   a_start: assert property (p_start)
      else $error("unpaced channel did not start");

   property p_paced;
      paced_r && mem_req && !mem_we |-> trig_ok_r;
   endproperty
   a_paced: assert property (p_paced)
      else $error("paced read without a codec trigger");
endmodule // cpdma_channel_chk

bind cpdma_channel cpdma_channel_chk #(.AW(AW), .MAW(MAW)) chk_u (
   .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .codec_trig(codec_trig), .mem_req(mem_req),
   .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
   .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
   .chan_clk_en(chan_clk_en)
);

// ---- testbench/cpdma_mem_model.sv ----
// word memory on the far side of the channel, fast or stalling
`timescale 1ns/10ps
module cpdma_mem_model (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic slow,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [12:0] mem_addr,
   input wire logic [15:0] mem_wdata,
   output logic mem_gnt,
   output logic mem_rvalid,
   output logic [15:0] mem_rdata
);
   logic [15:0] m [0:127];
   logic [15:0] word;
   logic tog, pend;
   logic [1:0] wait_c;

   // a slow memory grants only every other cycle
   assign mem_gnt = mem_req && (!slow || tog);

   // writes land at grant, reads answer two or four cycles later
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tog <= 1'b0;
         pend <= 1'b0;
         wait_c <= 2'h0;
         mem_rvalid <= 1'b0;
         mem_rdata <= 16'h0000;
      end else begin
         tog <= !tog;
         mem_rvalid <= 1'b0;
         mem_rdata <= ~mem_rdata; // idle data keeps changing
         if (mem_gnt && mem_we)
            m[mem_addr[6:0]] <= mem_wdata;
         if (mem_gnt && !mem_we) begin
            pend <= 1'b1;
            word <= m[mem_addr[6:0]];
            wait_c <= slow ? 2'h2 : 2'h0;
         end else if (pend && wait_c != 2'h0) begin
            wait_c <= wait_c - 2'h1;
         end else if (pend) begin
            pend <= 1'b0;
            mem_rvalid <= 1'b1;
            mem_rdata <= word;
         end
      end
   end
endmodule // cpdma_mem_model
